// File: hdl/fault_pkg.sv
package fault_pkg;
    // Clock rate and documented supervision times
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RELEASE_WAIT_MS = 300;
    localparam int unsigned STILL_ON_MS = 5000;
    localparam int unsigned REGEN_START_MS = 1000;
    localparam logic [31:0] RELEASE_WAIT_CYC = 32'(RELEASE_WAIT_MS * CLK_PER_MS);
    localparam logic [31:0] STILL_ON_CYC = 32'(STILL_ON_MS * CLK_PER_MS);
    localparam logic [31:0] REGEN_START_CYC = 32'(REGEN_START_MS * CLK_PER_MS);

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CDLY_OFS = 8'h04;
    localparam logic [7:0] CURMAX_OFS = 8'h08;
    localparam logic [7:0] OVLTIME_OFS = 8'h0C;
    localparam logic [7:0] RELEVEL_OFS = 8'h10;
    localparam logic [7:0] ERROR_OFS = 8'h14;
    localparam logic [7:0] ISTAT_OFS = 8'h18;
    localparam logic [7:0] IMASK_OFS = 8'h1C;
    localparam logic [7:0] STATE_OFS = 8'h20;

    // Field positions and reset values
    localparam int CFG_SEL_LSB = 0;
    localparam int OSPD_MASK_BIT = 5;
    localparam int CMON_EN_BIT = 6;
    localparam int INFO_LSB = 16;
    localparam logic [4:0] CFG_AUTO_OSPD = 5'h1F;
    localparam logic [6:0] CTRL_RESET = 7'h40;
    localparam logic [31:0] CDLY_RESET = 32'h000186A0;
    localparam logic [15:0] CURMAX_RESET = 16'hFFFF;
    localparam logic [31:0] OVLTIME_RESET = 32'h017D7840;
    localparam logic [15:0] RELEVEL_RESET = 16'h0100;

    // Event bit positions, shared by the status and mask registers
    localparam int NUM_EV = 9;
    localparam int EV_540 = 0;
    localparam int EV_544 = 1;
    localparam int EV_545 = 2;
    localparam int EV_546 = 3;
    localparam int EV_548 = 4;
    localparam int EV_549 = 5;
    localparam int EV_550 = 6;
    localparam int EV_560 = 7;
    localparam int EV_570 = 8;
    localparam int EV_571 = 9;
    localparam int NUM_IRQ = 10;

    // Error numbers
    localparam logic [9:0] ERR_NONE = 10'h000;
    localparam logic [9:0] ERR_540 = 10'h21C;
    localparam logic [9:0] ERR_544 = 10'h220;
    localparam logic [9:0] ERR_545 = 10'h221;
    localparam logic [9:0] ERR_546 = 10'h222;
    localparam logic [9:0] ERR_548 = 10'h224;
    localparam logic [9:0] ERR_549 = 10'h225;
    localparam logic [9:0] ERR_550 = 10'h226;
    localparam logic [9:0] ERR_560 = 10'h230;
    localparam logic [9:0] ERR_570 = 10'h23A;
    localparam logic [9:0] ERR_571 = 10'h23B;

    // Latched error number with additional information
    typedef struct packed {
        logic [9:0] num;
        logic [1:0] info;
    } err_t;

    // Software configuration steering the supervisor
    typedef struct packed {
        logic cmon_en;
        logic ospd_mask;
        logic [4:0] cfg_sel;
    } cfg_t;
endpackage : fault_pkg

// File: hdl/interval_timer.sv
`timescale 1ns/1ps
// One-shot down counter: start loads, done pulses once at expiry
module interval_timer #(
    parameter int W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic stop,
    input wire logic [W-1:0] load,
    output logic done,
    output logic running
);
    logic [W-1:0] cnt_reg;

    // Count down while running, a start restarts, a stop aborts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_reg <= (load == '0) ? W'(1) : load;
                running <= 1'b1;
            end
            else if (stop)
                running <= 1'b0;
            else if (running)
            begin
                if (cnt_reg == W'(1))
                begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - W'(1);
            end
        end
    end
endmodule : interval_timer

// File: hdl/drive_fault_supervisor.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module drive_fault_supervisor #(
    parameter logic [31:0] RELEASE_WAIT = fault_pkg::RELEASE_WAIT_CYC,
    parameter logic [31:0] STILL_ON = fault_pkg::STILL_ON_CYC,
    parameter logic [31:0] REGEN_START = fault_pkg::REGEN_START_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic travel_cmd,
    input wire logic contactor_feedback_a,
    input wire logic contactor_feedback_b,
    input wire logic controller_release_interrupt,
    input wire logic inverter_operating,
    input wire logic relevel_active,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] actual_speed,
    input wire logic regen_monitor_closed,
    input wire logic regen_active,
    output logic ready_release_output,
    output logic motion_release_output,
    output logic regen_fault,
    output logic param_set2_permit,
    output logic irq
);
    fault_pkg::cfg_t cfg_reg;
    logic [31:0] cdly_reg;
    logic [15:0] curmax_reg;
    logic [31:0] ovltime_reg;
    logic [15:0] relevel_reg;
    fault_pkg::err_t err_reg;
    fault_pkg::err_t err_next;
    logic [fault_pkg::NUM_IRQ-1:0] istat_reg;
    logic [fault_pkg::NUM_IRQ-1:0] imask_reg;
    logic [fault_pkg::NUM_IRQ-1:0] ev;
    logic [1:0] cinfo;
    logic [1:0] open_info;
    logic [1:0] still_info;
    logic travel_q, off_phase_reg, contactor_ok_reg, dropped_reg;
    logic ospd_q, ovl_fired_reg;
    logic [31:0] ovl_cnt_reg;
    logic travel_start, travel_end, drop_ev, ospd_now, regen_fault_now;
    logic cdly_done, still_done, wait_done, regen_done;
    logic wr_en, err_clr;
    logic [3:0] tmr_start, tmr_stop, tmr_done;
    logic [31:0] tmr_load [4];

    assign travel_start = travel_cmd & ~travel_q;
    assign travel_end = ~travel_cmd & travel_q;
    assign wr_en = psel & penable & pready & pwrite; // Writes land at the completing access edge
    assign err_clr = wr_en && (paddr == fault_pkg::ERROR_OFS);
    assign open_info = {~contactor_feedback_b, ~contactor_feedback_a};
    assign still_info = {contactor_feedback_b, contactor_feedback_a};
    assign drop_ev = travel_cmd & ~dropped_reg & (controller_release_interrupt | ev[fault_pkg::EV_545]
                     | ev[fault_pkg::EV_546]);
    assign ospd_now = relevel_active && (actual_speed > relevel_reg)
                      && (cfg_reg.ospd_mask || cfg_reg.cfg_sel == fault_pkg::CFG_AUTO_OSPD);
    assign regen_fault_now = inverter_operating & ~regen_monitor_closed;

    // Timers: check delay, still-on window, release wait, feedback unit start-up
    assign tmr_start = {travel_start, drop_ev, cdly_done & off_phase_reg, travel_start | travel_end};
    assign tmr_stop = {travel_end, 1'b0, travel_start, 1'b0};
    assign tmr_load = '{cdly_reg, STILL_ON, RELEASE_WAIT, REGEN_START};
    assign {regen_done, wait_done, still_done, cdly_done} = tmr_done;
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_tmr
            interval_timer #(.W(32)) tmr (
                .pclk(pclk),
                .presetn(presetn),
                .start(tmr_start[i]),
                .stop(tmr_stop[i]),
                .load(tmr_load[i]),
                .done(tmr_done[i]),
                .running()
            );
        end
    endgenerate

    // Fault events, one cycle each
    always_comb
    begin
        ev = '0;
        ev[fault_pkg::EV_540] = cfg_reg.cmon_en && cdly_done && !off_phase_reg && travel_cmd
                                && (open_info != 2'b00);
        ev[fault_pkg::EV_545] = cfg_reg.cmon_en && travel_cmd && contactor_ok_reg
                                && (open_info == 2'b01 || open_info == 2'b10);
        ev[fault_pkg::EV_546] = cfg_reg.cmon_en && travel_cmd && contactor_ok_reg
                                && (open_info == 2'b11);
        ev[fault_pkg::EV_544] = wait_done && travel_cmd;
        ev[fault_pkg::EV_548] = cfg_reg.cmon_en && still_done && contactor_feedback_a;
        ev[fault_pkg::EV_549] = cfg_reg.cmon_en && still_done && (still_info != 2'b00);
        ev[fault_pkg::EV_550] = (motor_current > curmax_reg) && (ovl_cnt_reg == ovltime_reg)
                                && !ovl_fired_reg;
        ev[fault_pkg::EV_560] = ospd_now && !ospd_q;
        ev[fault_pkg::EV_570] = regen_fault_now && !regen_fault;
        ev[fault_pkg::EV_571] = regen_done && !regen_active;
    end

    // Error selection by priority, with the input pattern as extra information
    always_comb
    begin
        cinfo = 2'b00;
        err_next = err_reg;
        if (ev[fault_pkg::EV_540])
        begin
            err_next.num = fault_pkg::ERR_540;
            cinfo = open_info;
        end
        else if (ev[fault_pkg::EV_546])
            err_next.num = fault_pkg::ERR_546;
        else if (ev[fault_pkg::EV_545])
        begin
            err_next.num = fault_pkg::ERR_545;
            cinfo = open_info;
        end
        else if (ev[fault_pkg::EV_549])
        begin
            err_next.num = fault_pkg::ERR_549;
            cinfo = still_info;
        end
        else if (ev[fault_pkg::EV_548])
            err_next.num = fault_pkg::ERR_548;
        else if (ev[fault_pkg::EV_544])
            err_next.num = fault_pkg::ERR_544;
        else if (ev[fault_pkg::EV_550])
            err_next.num = fault_pkg::ERR_550;
        else if (ev[fault_pkg::EV_560])
            err_next.num = fault_pkg::ERR_560;
        else if (ev[fault_pkg::EV_570])
            err_next.num = fault_pkg::ERR_570;
        else if (ev[fault_pkg::EV_571])
            err_next.num = fault_pkg::ERR_571;
        err_next.info = (ev != '0) ? cinfo : err_reg.info;
    end

    // Latched error: first fault holds, except 570 which clears itself when its fault ends, a new event beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_reg <= '0;
        else if (ev != '0 && (err_reg.num == fault_pkg::ERR_NONE || err_clr))
            err_reg <= err_next;
        else if (err_clr)
            err_reg <= '0;
        else if (err_reg.num == fault_pkg::ERR_570 && !regen_fault_now)
            err_reg <= '0;
    end

    // Travel sequencing and contactor state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            travel_q <= 1'b0;
            off_phase_reg <= 1'b0;
            contactor_ok_reg <= 1'b0;
        end
        else
        begin
            travel_q <= travel_cmd;
            if (travel_start)
                off_phase_reg <= 1'b0;
            else if (travel_end)
                off_phase_reg <= 1'b1;
            if (!travel_cmd || ev[fault_pkg::EV_545] || ev[fault_pkg::EV_546])
                contactor_ok_reg <= 1'b0;
            else if (cdly_done && !off_phase_reg && open_info == 2'b00)
                contactor_ok_reg <= 1'b1;
        end
    end

    // Release outputs, dropped on controller release or contactor interruption
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dropped_reg <= 1'b0;
            ready_release_output <= 1'b0;
            motion_release_output <= 1'b0;
        end
        else
        begin
            if (!travel_cmd)
                dropped_reg <= 1'b0;
            else if (drop_ev)
                dropped_reg <= 1'b1;
            ready_release_output <= travel_cmd & ~dropped_reg & ~drop_ev;
            motion_release_output <= travel_cmd & ~dropped_reg & ~drop_ev
                                     & (contactor_ok_reg | ~cfg_reg.cmon_en);
        end
    end

    // Overload time counter and level trackers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovl_cnt_reg <= '0;
            ovl_fired_reg <= 1'b0;
            ospd_q <= 1'b0;
            regen_fault <= 1'b0;
            param_set2_permit <= 1'b0;
        end
        else
        begin
            if (motor_current <= curmax_reg)
            begin
                ovl_cnt_reg <= '0;
                ovl_fired_reg <= 1'b0;
            end
            else if (ovl_cnt_reg != ovltime_reg)
                ovl_cnt_reg <= ovl_cnt_reg + 32'h00000001;
            else
                ovl_fired_reg <= 1'b1;
            ospd_q <= ospd_now;
            regen_fault <= regen_fault_now;
            param_set2_permit <= regen_fault_now;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= fault_pkg::CTRL_RESET;
            cdly_reg <= fault_pkg::CDLY_RESET;
            curmax_reg <= fault_pkg::CURMAX_RESET;
            ovltime_reg <= fault_pkg::OVLTIME_RESET;
            relevel_reg <= fault_pkg::RELEVEL_RESET;
            imask_reg <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == fault_pkg::CTRL_OFS)
                cfg_reg <= pwdata[6:0];
            else if (paddr == fault_pkg::CDLY_OFS)
                cdly_reg <= pwdata;
            else if (paddr == fault_pkg::CURMAX_OFS)
                curmax_reg <= pwdata[15:0];
            else if (paddr == fault_pkg::OVLTIME_OFS)
                ovltime_reg <= pwdata;
            else if (paddr == fault_pkg::RELEVEL_OFS)
                relevel_reg <= pwdata[15:0];
            else if (paddr == fault_pkg::IMASK_OFS)
                imask_reg <= pwdata[fault_pkg::NUM_IRQ-1:0];
        end
    end

    // Sticky status, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == fault_pkg::ISTAT_OFS)
                istat_reg <= (istat_reg & ~pwdata[fault_pkg::NUM_IRQ-1:0]) | ev;
            else
                istat_reg <= istat_reg | ev;
            irq <= |((istat_reg | ev) & imask_reg);
        end
    end

    // APB answer: data prepared in setup, pready high for the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= '0;
                if (paddr == fault_pkg::CTRL_OFS)
                    prdata <= {25'h0000000, cfg_reg};
                else if (paddr == fault_pkg::CDLY_OFS)
                    prdata <= cdly_reg;
                else if (paddr == fault_pkg::CURMAX_OFS)
                    prdata <= {16'h0000, curmax_reg};
                else if (paddr == fault_pkg::OVLTIME_OFS)
                    prdata <= ovltime_reg;
                else if (paddr == fault_pkg::RELEVEL_OFS)
                    prdata <= {16'h0000, relevel_reg};
                else if (paddr == fault_pkg::ERROR_OFS)
                    prdata <= {14'h0000, err_reg.info, 6'h00, err_reg.num};
                else if (paddr == fault_pkg::ISTAT_OFS)
                    prdata <= {22'h000000, istat_reg};
                else if (paddr == fault_pkg::IMASK_OFS)
                    prdata <= {22'h000000, imask_reg};
                else if (paddr == fault_pkg::STATE_OFS)
                    prdata <= {25'h0000000, regen_fault, dropped_reg, contactor_ok_reg, off_phase_reg,
                               contactor_feedback_b, contactor_feedback_a, travel_cmd};
                else
                    pslverr <= 1'b1; // Unmapped address
            end
        end
    end
endmodule : drive_fault_supervisor

// File: bench/drive_fault_supervisor_chk.sv
`timescale 1ns/1ps
// Port-level checks of the bus answer and the fault outputs
module drive_fault_supervisor_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic travel_cmd,
    input wire logic contactor_feedback_a,
    input wire logic inverter_operating,
    input wire logic regen_monitor_closed,
    input wire logic ready_release_output,
    input wire logic motion_release_output,
    input wire logic regen_fault,
    input wire logic param_set2_permit
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Zero-wait-state answer, only in the access phase
    apb_answer_a: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    ready_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access phase");
    // Error response for places past the map, none inside it
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h20 |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped place not refused");
    mapped_ok_a: assert property (psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped place refused");
    // Feedback unit contact supervision
    regen_raise_a: assert property (inverter_operating && !regen_monitor_closed |=> regen_fault)
        else $error("feedback unit fault missing");
    regen_clear_a: assert property (regen_monitor_closed |=> !regen_fault)
        else $error("feedback unit fault not cleared");
    permit_follow_a: assert property (param_set2_permit == regen_fault)
        else $error("second set permit wrong");
    // Contactor opening in travel drops both releases
    release_drop_a: assert property (
        motion_release_output && travel_cmd && $fell(contactor_feedback_a)
        |-> ##[1:2] !motion_release_output && !ready_release_output)
        else $error("releases kept after contactor opened");
endmodule : drive_fault_supervisor_chk

// File: bench/lift_side_model.sv
`timescale 1ns/1ps
// Lift controller, motor contactors and feedback unit contacts
module lift_side_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ready_release_output,
    input wire logic motion_release_output,
    input wire logic want_travel,
    input wire logic slow_withdraw,
    input wire logic [1:0] close_mask,
    input wire logic [1:0] drop_mask,
    input wire logic [1:0] stuck_mask,
    input wire logic regen_open,
    input wire logic regen_ok,
    output logic travel_cmd,
    output logic contactor_feedback_a,
    output logic contactor_feedback_b,
    output logic regen_monitor_closed,
    output logic regen_active
);
    logic rel_seen;
    logic [1:0] fb;

    // Command withdrawn one cycle after releases fall, unless told to dawdle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            travel_cmd <= 1'b0;
            rel_seen <= 1'b0;
            regen_active <= 1'b0;
        end
        else
        begin
            rel_seen <= want_travel && (rel_seen || motion_release_output);
            travel_cmd <= want_travel && !(rel_seen && !ready_release_output && !slow_withdraw);
            regen_active <= travel_cmd && regen_ok;
        end
    end

    // Contactors follow the command; faults open or weld them
    assign fb = ({2{travel_cmd}} & close_mask | stuck_mask) & ~drop_mask;
    assign contactor_feedback_a = fb[0];
    assign contactor_feedback_b = fb[1];
    assign regen_monitor_closed = !regen_open;
endmodule : lift_side_model

// File: bench/drive_fault_supervisor_test.sv
`timescale 1ns/1ps
// Self-checking bench: APB master, read scoreboard, fault scenarios
module drive_fault_supervisor_test;
    localparam logic [31:0] RW = 32'h00000032;
    localparam logic [31:0] SO = 32'h000000C8;
    localparam logic [31:0] RS = 32'h00000064;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, cd;
    logic pready, pslverr, travel_cmd, fb_a, fb_b, regen_closed, regen_active, rdy_rel, mot_rel;
    logic regen_fault, permit, irq, relevel = 1'b0, rf_int = 1'b0, inv_on = 1'b1;
    logic want_travel = 1'b0, slow = 1'b0, regen_open = 1'b0, regen_ok = 1'b1;
    logic [1:0] close_mask = 2'h3, drop_mask = 2'h0, stuck_mask = 2'h0;
    logic [15:0] current = 16'h0000, speed = 16'h0000;
    logic [31:0] exp_q[$], msk_q[$];
    string name_q[$];
    int fails = 0, compares = 0;

    // Clock
    initial forever #20 pclk = ~pclk;

    drive_fault_supervisor #(.RELEASE_WAIT(RW), .STILL_ON(SO), .REGEN_START(RS)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .travel_cmd(travel_cmd),
        .contactor_feedback_a(fb_a), .contactor_feedback_b(fb_b), .controller_release_interrupt(rf_int),
        .inverter_operating(inv_on), .relevel_active(relevel), .motor_current(current),
        .actual_speed(speed), .regen_monitor_closed(regen_closed), .regen_active(regen_active),
        .ready_release_output(rdy_rel), .motion_release_output(mot_rel), .regen_fault(regen_fault),
        .param_set2_permit(permit), .irq(irq));

    lift_side_model i_far (
        .pclk(pclk), .presetn(presetn), .ready_release_output(rdy_rel), .motion_release_output(mot_rel),
        .want_travel(want_travel), .slow_withdraw(slow), .close_mask(close_mask), .drop_mask(drop_mask),
        .stuck_mask(stuck_mask), .regen_open(regen_open), .regen_ok(regen_ok), .travel_cmd(travel_cmd),
        .contactor_feedback_a(fb_a), .contactor_feedback_b(fb_b), .regen_monitor_closed(regen_closed),
        .regen_active(regen_active));

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer, held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        name_q.push_back(n);
        xfer(1'b0, a, 32'h00000000);
    endtask : rd

    // Clear the latched error and every status bit
    task automatic clr;
        xfer(1'b1, fault_pkg::ERROR_OFS, 32'h00000000);
        xfer(1'b1, fault_pkg::ISTAT_OFS, 32'h000003FF);
        tick(1); // Interrupt level follows the status one edge later
    endtask : clr

    // Compare each completed read with the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk(name_q.pop_front(), prdata & msk_q.pop_front(), exp_q.pop_front());
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h1D834D56));
        tick(10);
        presetn <= 1'b1;
        tick(1);
        rd(fault_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h00000040, "ctrl");
        rd(fault_pkg::CDLY_OFS, 32'hFFFFFFFF, 32'h000186A0, "delay");
        rd(8'h24, 32'hFFFFFFFF, 32'h00000000, "unmapped");
        cd = 32'h00000010 + 32'($urandom % 16);
        xfer(1'b1, fault_pkg::CDLY_OFS, cd);
        xfer(1'b1, fault_pkg::IMASK_OFS, 32'h000003FF);
        for (int k = 1; k <= 3; k++)
        begin
            close_mask <= 2'(3 - k);
            want_travel <= 1'b1;
            tick(cd + 10);
            rd(fault_pkg::ERROR_OFS, 32'h0003FFFF, (32'(k) << 16) | 32'h0000021C, "missing");
            chk("irq", 32'(irq), 32'h00000001);
            want_travel <= 1'b0;
            clr();
            chk("irq", 32'(irq), 32'h00000000);
        end
        close_mask <= 2'h3;
        for (int k = 0; k < 3; k++)
        begin
            slow <= (k != 1);
            want_travel <= 1'b1;
            tick(cd + 10);
            chk("motion", 32'(mot_rel), 32'h00000001);
            drop_mask <= (k == 0) ? 2'h1 : (k == 1) ? 2'h3 : 2'h0;
            rf_int <= (k == 2);
            tick(RW + 10);
            rd(fault_pkg::ERROR_OFS, k == 1 ? 32'h000003FF : 32'h0003FFFF,
               k == 0 ? 32'h00010221 : k == 1 ? 32'h00000222 : 32'h00000220, "open");
            rd(fault_pkg::ISTAT_OFS, 32'h0000000E, k == 0 ? 32'h00000006 : k == 1 ? 32'h00000008 : 32'h00000002,
               "stop");
            want_travel <= 1'b0;
            drop_mask <= 2'h0;
            rf_int <= 1'b0;
            clr();
        end
        want_travel <= 1'b1;
        tick(cd + 10);
        want_travel <= 1'b0;
        stuck_mask <= 2'h1;
        tick(cd + SO + 20);
        rd(fault_pkg::ISTAT_OFS, 32'h00000030, 32'h00000030, "still on");
        rd(fault_pkg::ERROR_OFS, 32'h0003FFFF, 32'h00010225, "still on");
        stuck_mask <= 2'h0;
        clr();
        xfer(1'b1, fault_pkg::CURMAX_OFS, 32'h00000064);
        xfer(1'b1, fault_pkg::OVLTIME_OFS, 32'h0000000A);
        xfer(1'b1, fault_pkg::IMASK_OFS, 32'h000003BF);
        for (int n = 10; n <= 12; n += 2)
        begin
            current <= 16'h0065 + 16'($urandom % 64);
            tick(n);
            current <= 16'h0000;
            tick(2);
            rd(fault_pkg::ISTAT_OFS, 32'h00000040, n > 11 ? 32'h00000040 : 32'h00000000, "overload");
        end
        chk("irq masked", 32'(irq), 32'h00000000);
        xfer(1'b1, fault_pkg::IMASK_OFS, 32'h000003FF);
        tick(1);
        chk("irq", 32'(irq), 32'h00000001);
        clr();
        relevel <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, fault_pkg::CTRL_OFS, k == 0 ? 32'h00000040 : k == 1 ? 32'h00000060 : 32'h0000005F);
            speed <= 16'h0101 + 16'($urandom % 256);
            tick(3);
            speed <= 16'h0000;
            tick(2);
            rd(fault_pkg::ISTAT_OFS, 32'h00000080, k ? 32'h00000080 : 32'h00000000, "overspeed");
            clr();
        end
        relevel <= 1'b0;
        inv_on <= 1'b0;
        regen_open <= 1'b1;
        tick(3);
        chk("regen fault", 32'(regen_fault), 32'h00000000);
        inv_on <= 1'b1;
        tick(3);
        chk("regen fault", 32'(regen_fault), 32'h00000001);
        chk("permit", 32'(permit), 32'h00000001);
        rd(fault_pkg::ERROR_OFS, 32'h000003FF, 32'h0000023A, "regen");
        regen_open <= 1'b0;
        tick(3);
        chk("regen fault", 32'(regen_fault), 32'h00000000);
        rd(fault_pkg::ERROR_OFS, 32'h000003FF, 32'h00000000, "regen");
        clr();
        regen_ok <= 1'b0;
        want_travel <= 1'b1;
        tick(RS + 10);
        rd(fault_pkg::ISTAT_OFS, 32'h00000200, 32'h00000200, "regen start");
        rd(fault_pkg::ERROR_OFS, 32'h000003FF, 32'h0000023B, "regen start");
        want_travel <= 1'b0;
        tick(5);
        end_sim();
    end
endmodule : drive_fault_supervisor_test

bind drive_fault_supervisor drive_fault_supervisor_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .travel_cmd(travel_cmd), .contactor_feedback_a(contactor_feedback_a),
    .inverter_operating(inverter_operating), .regen_monitor_closed(regen_monitor_closed),
    .ready_release_output(ready_release_output), .motion_release_output(motion_release_output),
    .regen_fault(regen_fault), .param_set2_permit(param_set2_permit));
